// *** hw/sdl_pkg.sv ***
package sdl_pkg;
    // Frame layout
    localparam int WORD_BITS     = 16;              // Bits per frame
    localparam int MODE_HI_POS   = 15;              // mode_bit_high position
    localparam int MODE_LO_POS   = 14;              // mode_bit_low position
    localparam int CODE_BITS     = 14;              // Converter code width
    localparam logic [13:0] CODE_RESET = 14'h0000;  // Power-on code, 0 V
    // Link timing
    localparam int CLK_MHZ       = 50;              // hclk rate
    localparam int SYNC_HIGH_NS  = 33;              // Least sync high time
    localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS * CLK_MHZ + 999) / 1000;  // Rounded up
    localparam int SCLK_DIV      = 4;               // hclk cycles per sclk half period
    // Host register map (byte addresses)
    localparam logic [7:0] REG_DATA   = 8'h00;      // Word to send
    localparam logic [7:0] REG_STATUS = 8'h04;      // Bit 0 busy
    localparam logic [7:0] REG_CTRL   = 8'h08;      // Bit 0 idle sync low
    // Operating modes
    typedef enum logic [1:0] {
        SDL_MODE_NORMAL = 2'b00,                    // Amplifier drives output
        SDL_MODE_PD_1K  = 2'b01,                    // 1k to ground
        SDL_MODE_PD_100K = 2'b10,                   // 100k to ground
        SDL_MODE_PD_HIZ = 2'b11                     // Output open
    } sdl_mode_type;
endpackage

// *** hw/sdl_link_if.sv ***
interface sdl_link_if;
    logic sync_n;   // Active-low frame sync
    logic sclk;     // Shift clock
    logic din;      // Serial data, MSB first
    // Host drives all three wires
    modport host (output sync_n, output sclk, output din);
    // Converter only listens
    modport dev  (input sync_n, input sclk, input din);
endinterface

// *** hw/sdl_dev.sv ***
// Overview of operation
// [R1] Host lowers sync before first clock fall
// [R2] Shift data in on falling clock edges
// [R3] Host clock at most 30 MHz
// [R4] Sixteenth edge executes the word at once
// [R5] Sync high 33 ns between frames
// [R6] New word only after sync falls
// [R7] Host may idle sync low
// [R8] First two bits select operating mode
// [R9] Remaining bits load converter code
// [R10] Host sends MSB first
// [R11] Sync low for sixteen falling edges
// [R12] Early sync rise discards the frame
// [R13] Power-on code is zero
// [R14] Mode bits decode four output states
// [R15] Power-down disconnects amplifier from pin
// [R16] Power-down keeps the converter code; here a power-down word still reloads code from its low 14 bits
// [R17] Byte hosts keep sync low across bytes
// [R18] Host uses clock polarity 0, phase 1
// [R19] Sync low enables shifting
// [R20] Ignore clocks after execution until sync rises
module sdl_dev
    import sdl_pkg::*;
(
    // Clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // Serial link
    sdl_link_if.dev                          link,
    // Converter side
    output logic [sdl_pkg::CODE_BITS-1:0]    code,
    output sdl_pkg::sdl_mode_type            mode,
    output logic                             amp_on,
    output logic                             term_1k,
    output logic                             term_100k,
    output logic                             word_done
);
    import sdl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: pins are asynchronous to hclk, so each one passes
    // two flops before any logic reads it; the taps above the settled
    // stage give the history used for edge detection
    logic [2:0] sync_taps;  // Frame sync: settled, then history
    logic [2:0] sclk_taps;  // Shift clock: settled, then history
    logic [1:0] din_taps;   // Data: settled, then one delay

    // Frame sync idles high, so its chain resets high to avoid a false fall
    sdl_sync #(
        .DEPTH   (3),
        .INIT    (1'b1)
    ) sync_chain_i (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (link.sync_n),
        .taps    (sync_taps)
    );

    // Shift clock idles low
    sdl_sync #(
        .DEPTH   (3),
        .INIT    (1'b0)
    ) sclk_chain_i (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (link.sclk),
        .taps    (sclk_taps)
    );

    // Data takes the same delay as the clock so each bit meets its edge
    sdl_sync #(
        .DEPTH   (2),
        .INIT    (1'b0)
    ) din_chain_i (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (link.din),
        .taps    (din_taps)
    );

    // Limitation: each shift clock half period must span at least two
    // hclk cycles to be seen, so the host must run the link well below
    // its top rate; the frame logic itself does not care about the rate
    // Edge decoding on the settled copies; bit 1 sits one flop past the
    // settled stage so that bit 2 can serve as its history
    wire sync_low  = ~sync_taps[1];                      // [R19]
    wire sync_fall = sync_taps[2] & ~sync_taps[1];       // [R6]
    wire sync_rise = ~sync_taps[2] & sync_taps[1];       // [R12]
    wire sclk_fall = sclk_taps[2] & ~sclk_taps[1];       // [R2]
    wire din_bit   = din_taps[1];                        // Aligned with sclk_taps[1]

    ////////////////////////////////////////////////////////////////////////
    // Frame state
    typedef enum logic [1:0] {
        ST_IDLE,    // Waiting for sync to fall
        ST_SHIFT,   // Taking bits
        ST_DONE     // Executed, waiting for sync to rise
    } sdl_state_type;

    sdl_state_type             state_q, state_d;
    logic [WORD_BITS-1:0]      shift_q, shift_d;   // Input shift register
    logic [4:0]                cnt_q, cnt_d;       // Bits taken so far
    logic [CODE_BITS-1:0]      code_q, code_d;     // Converter register
    sdl_mode_type              mode_q, mode_d;     // Operating mode
    logic                      done_q, done_d;     // Execute pulse

    // Word as it will stand after the current falling edge
    wire [WORD_BITS-1:0] next_word = {shift_q[WORD_BITS-2:0], din_bit};
    wire                 last_bit  = (cnt_q == 5'(WORD_BITS - 1));

    // Next state and load decisions
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d   = cnt_q;
        code_d  = code_q;
        mode_d  = mode_q;
        done_d  = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (sync_fall) begin                     // [R6]
                    state_d = ST_SHIFT;
                    shift_d = '0;
                    cnt_d   = '0;
                end
            end
            ST_SHIFT: begin
                if (!sync_low) begin
                    // Abort: clear and keep code and mode
                    state_d = ST_IDLE;                   // [R12]
                    shift_d = '0;                        // [R12]
                    cnt_d   = '0;
                end else if (sclk_fall) begin
                    shift_d = next_word;                 // [R2]
                    cnt_d   = cnt_q + 5'd1;
                    if (last_bit) begin
                        // Execute immediately on the sixteenth edge
                        state_d = ST_DONE;               // [R4]
                        mode_d  = sdl_mode_type'(next_word[MODE_HI_POS:MODE_LO_POS]); // [R8]
                        code_d  = next_word[CODE_BITS-1:0];  // [R9]
                        done_d  = 1'b1;
                    end
                end
            end
            ST_DONE: begin
                // Further clock edges ignored while sync stays low
                if (sync_rise) begin                     // [R20]
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Frame registers; code and mode both reload on every executed word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            shift_q <= '0;
            cnt_q   <= '0;
            code_q  <= CODE_RESET;                       // [R13]
            mode_q  <= SDL_MODE_NORMAL;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            code_q  <= code_d;                           // [R16]
            mode_q  <= mode_d;
            done_q  <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage control
    assign code      = code_q;
    assign mode      = mode_q;
    assign word_done = done_q;
    assign amp_on    = (mode_q == SDL_MODE_NORMAL);      // [R15]
    assign term_1k   = (mode_q == SDL_MODE_PD_1K);       // [R14]
    assign term_100k = (mode_q == SDL_MODE_PD_100K);     // [R14]

endmodule // sdl_dev

////////////////////////////////////////////////////////////////////////
// Pin synchroniser: a first flop, then DEPTH more; only the second flop
// reads the first, so a metastable sample has a whole cycle to settle
module sdl_sync #(
    parameter int   DEPTH = 3,          // Settled stage plus history
    parameter logic INIT  = 1'b0        // Idle level of the pin
) (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // Asynchronous pin and its settled copies
    input  wire logic                   pin,
    output logic [DEPTH-1:0]            taps
);
    logic             meta_q;           // First stage, read only by the second
    logic [DEPTH-1:0] taps_q;           // Second stage in bit 0, older above

    // Shift the pin through the chain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= INIT;
            taps_q <= {DEPTH{INIT}};
        end else begin
            meta_q <= pin;
            taps_q <= {taps_q[DEPTH-2:0], meta_q};
        end
    end

    assign taps = taps_q;

endmodule // sdl_sync

// *** hw/sdl_host.sv ***
module sdl_host
    import sdl_pkg::*;
(
    // Clock and reset
    input  wire logic           hclk,
    input  wire logic           hresetn,
    // AHB-Lite slave
    input  wire logic           hsel,
    input  wire logic [7:0]     haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic           hready,
    input  wire logic [31:0]    hwdata,
    output logic [31:0]         hrdata,
    output logic                hreadyout,
    output logic                hresp,
    // Serial link
    sdl_link_if.host            link
);
    import sdl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase capture
    logic       wr_q;       // Data phase is a write
    logic [7:0] addr_q;     // Address of the data phase
    wire        acc = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q   <= acc & hwrite;
            addr_q <= haddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit engine
    typedef enum logic [1:0] {
        TX_IDLE,    // Nothing to send
        TX_GAP,     // Sync high before the frame
        TX_BITS,    // Clocking out sixteen bits
        TX_HOLD     // Sync kept low past the last fall
    } sdl_tx_type;

    sdl_tx_type       st_q;
    logic [15:0]      sh_q;         // Outgoing word, MSB first
    logic [4:0]       bit_q;        // Bits still to send
    logic [7:0]       div_q;        // Half period counter
    logic             sclk_q;
    logic             sync_n_q;
    logic             idle_low_q;   // Idle sync low between frames
    wire              start = wr_q & (addr_q == REG_DATA) & (st_q == TX_IDLE);
    wire              tick  = (div_q == 8'(SCLK_DIV - 1));
    wire              gap_ok = (div_q >= 8'(SYNC_HIGH_CYC + SCLK_DIV));

    // Frame generation; clock idles low, data changes on rising edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q     <= TX_IDLE;
            sh_q     <= 16'h0000;
            bit_q    <= 5'h00;
            div_q    <= 8'h00;
            sclk_q   <= 1'b0;
            sync_n_q <= 1'b1;
        end else begin
            case (st_q)
                TX_IDLE: begin
                    sync_n_q <= ~idle_low_q;             // [R7]
                    sclk_q   <= 1'b0;
                    if (start) begin
                        sh_q     <= hwdata[15:0];        // [R10]
                        st_q     <= TX_GAP;
                        sync_n_q <= 1'b1;                // [R5]
                        div_q    <= 8'h00;
                    end
                end
                TX_GAP: begin
                    div_q <= div_q + 8'h01;
                    if (gap_ok) begin
                        sync_n_q <= 1'b0;                // [R1]
                        bit_q    <= 5'(WORD_BITS);       // [R11]
                        div_q    <= 8'h00;
                        st_q     <= TX_BITS;
                    end
                end
                TX_BITS: begin
                    div_q <= tick ? 8'h00 : div_q + 8'h01;
                    if (tick) begin
                        sclk_q <= ~sclk_q;               // [R18]
                        if (!sclk_q) begin
                            // Rising edge: next bit out, half a period before its fall
                            if (bit_q != 5'(WORD_BITS)) begin
                                sh_q <= {sh_q[14:0], 1'b0};  // [R10]
                            end
                        end else begin
                            // Falling edge: device takes the bit, data stays put
                            bit_q <= bit_q - 5'd1;
                            if (bit_q == 5'd1) begin
                                st_q <= TX_HOLD;         // [R11]
                            end
                        end
                    end
                end
                TX_HOLD: begin
                    // Raising sync with the last fall would race it through
                    // the far end's synchroniser and abort the word
                    div_q <= div_q + 8'h01;
                    if (tick) begin
                        st_q     <= TX_IDLE;             // [R17]
                        sync_n_q <= ~idle_low_q;
                    end
                end
                default: st_q <= TX_IDLE;
            endcase
        end
    end

    // Control register write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_low_q <= 1'b0;
        end else if (wr_q && addr_q == REG_CTRL) begin
            idle_low_q <= hwdata[0];
        end
    end

    assign link.sync_n = sync_n_q;
    assign link.sclk   = sclk_q;                         // [R3]
    assign link.din    = sh_q[15];

    // Read mux on the address phase; a control write still in its data
    // phase is passed through so a read right behind it sees the new bit
    wire         busy     = (st_q != TX_IDLE);
    wire         ctrl_now = (wr_q && addr_q == REG_CTRL) ? hwdata[0] : idle_low_q;
    wire  [31:0] rd_mux   = (haddr == REG_STATUS) ? {31'h0, busy} :
                            (haddr == REG_CTRL)   ? {31'h0, ctrl_now} : 32'h0;
    logic [31:0] rdata_q;   // Read data, stands through the data phase

    // Capture read data when a read address phase is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else if (acc && !hwrite) begin
            rdata_q <= rd_mux;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule // sdl_host

// *** bench/sdl_link_props.sv ***
module sdl_link_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link wires
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic din
);
    logic [4:0] falls_q;  // Clock falls seen in this frame

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////
    // Count falls; a new frame starts the count again
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            falls_q <= 5'h00;
        else if ($fell(sync_n))
            falls_q <= 5'h00;
        else if ($fell(sclk) && !sync_n)
            falls_q <= falls_q + 5'h01;
    end

    ////////////////////////////////////////////////////////////////
    chk_fall_in_frame: assert property ($fell(sclk) |-> !sync_n)
        else $error("clock fell outside a frame");
    chk_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("clock high half wrong");
    chk_low_half: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("clock low half too short");
    chk_sync_gap: assert property ($rose(sync_n) |-> sync_n[*2])
        else $error("sync high too short");
    chk_din_steady: assert property ($fell(sclk) |-> $stable(din))
        else $error("data moved at the sampling edge");
    chk_idle_clock: assert property (sync_n |-> !sclk)
        else $error("clock not idle low");
    chk_word_length: assert property ($rose(sync_n) && falls_q != 5'h00 |-> falls_q == 5'h10)
        else $error("frame not sixteen falls");
    chk_no_extra: assert property (falls_q <= 5'h10)
        else $error("more than sixteen falls");
endmodule // sdl_link_props

// *** bench/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sdl_pkg::*;
    // Clock, reset and bus master
    logic         hclk = 1'b0;
    logic         hresetn = 1'b0;
    logic         hsel = 1'b0;
    logic [1:0]   htrans = 2'h0;
    logic [7:0]   haddr = 8'h00;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic [2:0]   hsize = 3'h0;
    logic         done_a;     // Execute pulses of each converter
    logic         done_b;
    int           done_cnt_a = 0;
    int           done_cnt_b = 0;
    // Converter outputs: {amp_on, term_1k, term_100k}
    logic [13:0]  code_a;
    logic [13:0]  code_b;
    sdl_mode_type mode_a;
    sdl_mode_type mode_b;
    logic [2:0]   outs_a;
    logic [2:0]   outs_b;
    logic [15:0]  cap_q;      // Word seen on the wire
    logic [31:0]  r;
    logic [15:0]  w;
    int           num_errors = 0;
    int           compares = 0;
    sdl_link_if link_a();
    sdl_link_if link_b();     // Driven by the bench itself

    sdl_host sdl_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .link(link_a));
    sdl_dev sdl_dev_i (.hclk, .hresetn, .link(link_a), .code(code_a), .mode(mode_a),
        .amp_on(outs_a[2]), .term_1k(outs_a[1]), .term_100k(outs_a[0]), .word_done(done_a));
    sdl_dev sdl_dev_b_i (.hclk, .hresetn, .link(link_b), .code(code_b), .mode(mode_b),
        .amp_on(outs_b[2]), .term_1k(outs_b[1]), .term_100k(outs_b[0]), .word_done(done_b));
    sdl_link_props sdl_link_props_i (.hclk, .hresetn, .sync_n(link_a.sync_n),
        .sclk(link_a.sclk), .din(link_a.din));

    always #10 hclk = ~hclk;
    initial begin
        link_b.sync_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.din = 1'b0;
    end
    // Shift in what the host puts on the wire
    always @(negedge link_a.sclk) begin
        if (link_a.sync_n === 1'b0)
            cap_q = {cap_q[14:0], link_a.din};
    end
    // Count executed words, one per pulse
    always @(posedge hclk) begin
        if (done_a === 1'b1)
            done_cnt_a++;
        if (done_b === 1'b1)
            done_cnt_b++;
    end

    ////////////////////////////////////////////////////////////////
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task finish_test;
        $display("Compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One single transfer; called just after a rising edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // Send a word and poll busy, bounded
    task send_word(input logic [15:0] v);
        int n;
        n = 0;
        ahb(1'b1, REG_DATA, {16'h0, v}, r);
        repeat (2) @(posedge hclk);
        do begin
            ahb(1'b0, REG_STATUS, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 400);
        check("busy", 16'(r[0]), 16'h0);
        repeat (12) @(posedge hclk);
    endtask
    // Bench as host: data set on the rise, sampled on the fall
    task frame_b(input logic [15:0] v, input int falls);
        int i;
        link_b.sync_n <= 1'b0;
        repeat (4) @(posedge hclk);
        for (i = 0; i < falls; i++) begin
            link_b.din <= v[15 - (i % 16)] ^ (i >= 16);
            link_b.sclk <= 1'b1;
            repeat (4) @(posedge hclk);
            link_b.sclk <= 1'b0;
            repeat (4) @(posedge hclk);
            if (i == 7) begin
                repeat (20) @(posedge hclk);
            end
        end
        link_b.sync_n <= 1'b1;
        link_b.din <= ~link_b.din;
        repeat (8) @(posedge hclk);
    endtask
    function automatic logic [2:0] outs_of(input logic [1:0] m);
        return {m == 2'h0, m == 2'h1, m == 2'h2};
    endfunction

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("code_a", 16'(code_a), 16'h0);
        check("outs_a", 16'(outs_a), 16'h4);
        check("code_b", 16'(code_b), 16'h0);
        ahb(1'b0, REG_CTRL, 32'h0, r);
        check("ctrl", r[15:0], 16'h0);
        $display("Test reset done");
        for (int m = 0; m < 4; m++) begin
            w = {2'(m), 14'h2a5c ^ 14'(m)};
            send_word(w);
            check("wire word", cap_q, w);
            check("code_a", 16'(code_a), 16'(w[13:0]));
            check("mode_a", 16'(mode_a), 16'(w[15:14]));
            check("outs_a", 16'(outs_a), 16'(outs_of(w[15:14])));
        end
        $display("Test modes done");
        ahb(1'b1, REG_CTRL, 32'h1, r);
        send_word(16'h3fff);
        check("sync idle", 16'(link_a.sync_n), 16'h0);
        check("code_a", 16'(code_a), 16'h3fff);
        ahb(1'b1, REG_CTRL, 32'h0, r);
        send_word(16'h0001);
        check("code_a", 16'(code_a), 16'h0001);
        check("dones_a", 16'(done_cnt_a), 16'h6);
        ahb(1'b0, 8'h0c, 32'h0, r);
        check("hresp", 16'(hresp), 16'h0);
        $display("Test idle and bus done");
        frame_b(16'h5555, 20);
        check("code_b", 16'(code_b), 16'h1555);
        check("mode_b", 16'(mode_b), 16'h1);
        frame_b(16'hc0de, 8);
        check("code_b", 16'(code_b), 16'h1555);
        check("mode_b", 16'(mode_b), 16'h1);
        frame_b(16'h8123, 16);
        check("code_b", 16'(code_b), 16'h0123);
        check("mode_b", 16'(mode_b), 16'h2);
        check("dones_b", 16'(done_cnt_b), 16'h2);
        $display("Test far link done");
        finish_test();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        finish_test();
    end
endmodule // tb_top
